/* include/e1fmac_pkg.sv */
package e1fmac_pkg;
  // register port widths
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [4:0] OFS_MODE   = 5'h10;
  localparam logic [4:0] OFS_ALARM  = 5'h11;
  localparam logic [4:0] OFS_CTRL   = 5'h12;
  localparam logic [4:0] OFS_STATUS = 5'h13;
  localparam logic [4:0] OFS_ECNT_L = 5'h14;
  localparam logic [4:0] OFS_ECNT_H = 5'h15;

  // values after reset
  localparam logic [7:0] RST_MODE  = 8'h00;
  localparam logic [7:0] RST_ALARM = 8'h10;
  localparam logic [7:0] RST_CTRL  = 8'h30;

  // mode selection word fields
  localparam int MODE_AIS_SEL  = 7;
  localparam int MODE_REM_MOD  = 6;
  localparam int MODE_IW_DIS   = 5;
  localparam int MODE_RAI_DIS  = 4;
  localparam int MODE_Y_DIS    = 3;
  localparam int MODE_CRC_DIS  = 2;
  localparam int MODE_BREFRM   = 1;
  localparam int MODE_MREFRM   = 0;

  // transmit alarm word fields
  localparam int ALM_LOSS_POL  = 6;
  localparam int ALM_TS16_FILL = 5;
  localparam int ALM_ONES_N    = 4;
  localparam int ALM_ERR_POL   = 3;
  localparam int ALM_USED_LSB  = 3;

  // extra control word fields
  localparam int CTL_MAN_RAI   = 0;
  localparam int CTL_MAN_Y     = 1;
  localparam int CTL_ONES_FRM  = 2;
  localparam int CTL_TRANSP    = 3;
  localparam int CTL_IU0       = 4;
  localparam int CTL_IU1       = 5;
  localparam int CTL_USED_W    = 6;

  // frame structure
  localparam int BITS_PER_TS   = 8;
  localparam int TS_PER_FRAME  = 32;
  localparam int FRAMES_PER_MF = 16;
  localparam logic [4:0] TS_SIG = 5'h10;
  localparam logic [6:0] FAS_WORD = 7'h1B;
  localparam logic [5:0] MFAS_WORD = 6'h0B;
  localparam logic [3:0] EBIT_FRM_A = 4'hD;
  localparam logic [3:0] EBIT_FRM_B = 4'hF;
  localparam logic [7:0] ALL_ONES = 8'hFF;

  // alarm indication window
  localparam int AIS_WINDOW_BITS = 512;
  localparam logic [1:0] AIS_ZERO_LIMIT = 2'h3;

  // line bit rate as a clock divide, fifo depth, E-bit count width
  localparam int BIT_DIV_DEF    = 4;
  localparam int FIFO_DEPTH_DEF = 8;
  localparam int ECNT_W         = 16;
endpackage

/* rtl/e1fmac_fifo.sv */
module e1fmac_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // depth must be a power of two for pointer wrap
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [PW:0]      next_count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer and fill level
  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count  = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // storage, written only on push
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule // e1fmac_fifo

/* rtl/e1fmac_top.sv */
// Behaviour
// [RULE1] AIS on under three zeros
// [RULE2] remainder modify in transparent
// [RULE3] interworking unless disabled
// [RULE4] A bit auto or manual
// [RULE5] Y bit auto or manual
// [RULE6] CRC-4 or intl use bits
// [RULE7] basic reframe on falling bit
// [RULE8] mf reframe on falling bit
// [RULE9] reframe bit held one frame; hold time unchecked, any falling bit gives a one-cycle start pulse
// [RULE10] alarm bit 7 written zero; the register keeps bit 7 as written
// [RULE11] E bits result or loss value
// [RULE12] TS16 fill sends ones
// [RULE13] forced all ones on line
// [RULE14] E-bit count polarity
// [RULE15] transparent imposes no framing
// [RULE16] alarm bits 2..0 read zero
module e1fmac_top #(
  parameter int BIT_DIV    = e1fmac_pkg::BIT_DIV_DEF,
  parameter int FIFO_DEPTH = e1fmac_pkg::FIFO_DEPTH_DEF
) (
  input  wire logic                         ref_clk,
  input  wire logic                         arst_n,
  input  wire logic [e1fmac_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [e1fmac_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [e1fmac_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic [7:0]                   serial_tx_input,
  input  wire logic                         serial_tx_valid,
  output logic                              serial_tx_ready,
  input  wire logic                         basic_sync_ok,
  input  wire logic                         mf_aligned,
  input  wire logic                         crc_sync_ok,
  input  wire logic                         crc_cmp_result,
  input  wire logic                         tx_crc_bit,
  input  wire logic                         crc_delta_bit,
  input  wire logic                         rx_line_bit,
  input  wire logic                         rx_line_valid,
  input  wire logic                         rx_ebit,
  input  wire logic                         rx_ebit_valid,
  output logic                              line_out_tip,
  output logic                              line_out_ring,
  output logic                              ais_detected,
  output logic                              interwork_enable,
  output logic                              crc_enable,
  output logic                              basic_reframe_start,
  output logic                              mf_reframe_start,
  output logic                              ebit_error_event
);
  import e1fmac_pkg::*;

  if (BIT_DIV < 2 || BIT_DIV > 256) begin : g_bad_div
    $error("bit divider must lie in 2..256");
  end

  // register file
  logic [7:0] mode_selection_word;
  logic [7:0] transmit_alarm_word;
  logic [7:0] ctrl_word;
  logic [7:0] next_mode;
  logic [7:0] next_alarm;
  logic [7:0] next_ctrl;
  logic [7:0] next_rdata;
  logic [7:0] status_word;
  logic [ECNT_W-1:0] ebit_count;
  logic              fifo_valid;

  assign status_word = {3'h0, fifo_valid, ais_detected, crc_sync_ok,
                        mf_aligned, basic_sync_ok};

  // register writes and read mux
  always_comb begin
    next_mode  = mode_selection_word;
    next_alarm = transmit_alarm_word;
    next_ctrl  = ctrl_word;
    next_rdata = 8'h00;
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_MODE:  next_mode = reg_wdata;
        // bit 7 kept as written; software keeps it zero  [RULE10]
        OFS_ALARM: next_alarm = {reg_wdata[7:ALM_USED_LSB], 3'h0}; // [RULE16]
        OFS_CTRL:  next_ctrl = {2'h0, reg_wdata[CTL_USED_W-1:0]};
        default:   ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_MODE:   next_rdata = mode_selection_word;
        OFS_ALARM:  next_rdata = transmit_alarm_word;
        OFS_CTRL:   next_rdata = ctrl_word;
        OFS_STATUS: next_rdata = status_word;
        OFS_ECNT_L: next_rdata = ebit_count[7:0];
        OFS_ECNT_H: next_rdata = ebit_count[15:8];
        default:    next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_selection_word <= RST_MODE;
      transmit_alarm_word <= RST_ALARM;
      ctrl_word           <= RST_CTRL;
      reg_rdata           <= 8'h00;
    end else begin
      mode_selection_word <= next_mode;
      transmit_alarm_word <= next_alarm;
      ctrl_word           <= next_ctrl;
      reg_rdata           <= next_rdata;
    end
  end

  // decoded controls
  logic ais_criterion_select;
  logic remainder_modify_enable;
  logic auto_remote_alarm_disable;
  logic auto_ybit_disable;
  logic crc_sync_disable;
  logic ebit_loss_polarity;
  logic ts16_alarm_fill;
  logic line_all_ones_n;
  logic ebit_error_polarity;
  logic manual_remote_alarm;
  logic manual_ybit;
  logic all_ones_framed;
  logic tx_transparent_mode;
  logic intl_use_bit_zero;
  logic intl_use_bit_one;

  assign ais_criterion_select      = mode_selection_word[MODE_AIS_SEL];
  assign remainder_modify_enable   = mode_selection_word[MODE_REM_MOD];
  assign auto_remote_alarm_disable = mode_selection_word[MODE_RAI_DIS];
  assign auto_ybit_disable         = mode_selection_word[MODE_Y_DIS];
  assign crc_sync_disable          = mode_selection_word[MODE_CRC_DIS];
  assign ebit_loss_polarity        = transmit_alarm_word[ALM_LOSS_POL];
  assign ts16_alarm_fill           = transmit_alarm_word[ALM_TS16_FILL];
  assign line_all_ones_n           = transmit_alarm_word[ALM_ONES_N];
  assign ebit_error_polarity       = transmit_alarm_word[ALM_ERR_POL];
  assign manual_remote_alarm       = ctrl_word[CTL_MAN_RAI];
  assign manual_ybit               = ctrl_word[CTL_MAN_Y];
  assign all_ones_framed           = ctrl_word[CTL_ONES_FRM];
  assign tx_transparent_mode       = ctrl_word[CTL_TRANSP];
  assign intl_use_bit_zero         = ctrl_word[CTL_IU0];
  assign intl_use_bit_one          = ctrl_word[CTL_IU1];

  assign interwork_enable = !mode_selection_word[MODE_IW_DIS]; // [RULE3]
  assign crc_enable       = !crc_sync_disable; // [RULE6]

  // reframe requests on falling request bits
  logic prev_brefrm;
  logic prev_mrefrm;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_brefrm         <= 1'b0;
      prev_mrefrm         <= 1'b0;
      basic_reframe_start <= 1'b0;
      mf_reframe_start    <= 1'b0;
    end else begin
      prev_brefrm         <= mode_selection_word[MODE_BREFRM];
      prev_mrefrm         <= mode_selection_word[MODE_MREFRM];
      basic_reframe_start <= prev_brefrm &&
                             !mode_selection_word[MODE_BREFRM]; // [RULE7]
      mf_reframe_start    <= prev_mrefrm &&
                             !mode_selection_word[MODE_MREFRM]; // [RULE8]
    end
  end

  // transmit data buffer
  logic [7:0] fifo_data;
  logic       fifo_pop;

  e1fmac_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .in_data   (serial_tx_input),
    .in_valid  (serial_tx_valid),
    .in_ready  (serial_tx_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // transmit framer and serialiser
  logic [7:0] div_cnt;
  logic [2:0] bit_pos;
  logic [4:0] ts;
  logic [3:0] frame;
  logic [7:0] shift;
  logic       out_bit;
  logic [7:0] next_div_cnt;
  logic [2:0] next_bit_pos;
  logic [4:0] next_ts;
  logic [3:0] next_frame;
  logic [7:0] next_shift;
  logic       next_out_bit;
  logic       bit_en;
  logic       load;
  logic       need_data;
  logic [7:0] data_byte;
  logic [7:0] ts0_byte;
  logic [7:0] slot_byte;
  logic       fas_frame;
  logic       si_bit;
  logic       a_bit;
  logic       y_bit;
  logic       e_bit;

  assign bit_en    = (div_cnt == 8'(BIT_DIV - 1));
  assign load      = bit_en && (bit_pos == 3'h0);
  assign fas_frame = !frame[0];
  assign data_byte = fifo_valid ? fifo_data : ALL_ONES;
  assign fifo_pop  = load && need_data;

  // overhead bits and slot content
  always_comb begin
    a_bit = auto_remote_alarm_disable ? manual_remote_alarm
                                      : basic_sync_ok; // [RULE4]
    y_bit = auto_ybit_disable ? manual_ybit : !mf_aligned; // [RULE5]
    e_bit = crc_sync_ok ? crc_cmp_result : ebit_loss_polarity; // [RULE11]
    // Si bit: CRC and multiframe bits, or fixed bits
    if (fas_frame) begin
      si_bit = crc_enable ? tx_crc_bit : intl_use_bit_zero; // [RULE6]
    end else if (!crc_enable) begin
      si_bit = intl_use_bit_one; // [RULE6]
    end else if (frame == EBIT_FRM_A || frame == EBIT_FRM_B) begin
      si_bit = e_bit; // [RULE11]
    end else begin
      si_bit = MFAS_WORD[3'h5 - frame[3:1]];
    end
    ts0_byte = fas_frame ? {si_bit, FAS_WORD}
                         : {si_bit, 1'b1, a_bit, 5'h1F};
    need_data = 1'b1;
    if (tx_transparent_mode) begin
      // stream passes through without framing  [RULE15]
      slot_byte = data_byte;
      if (ts == 5'h00 && fas_frame && remainder_modify_enable) begin
        slot_byte[7] = data_byte[7] ^ crc_delta_bit; // [RULE2]
      end
    end else if (ts == 5'h00) begin
      need_data = 1'b0;
      slot_byte = ts0_byte;
    end else if (ts == TS_SIG && ts16_alarm_fill) begin
      slot_byte = ALL_ONES; // [RULE12]
      need_data = (frame != 4'h0);
    end else if (ts == TS_SIG && frame == 4'h0) begin
      need_data = 1'b0;
      slot_byte = {4'h0, 1'b1, y_bit, 2'h3}; // [RULE5]
    end else begin
      slot_byte = data_byte;
    end
    if (!line_all_ones_n) begin
      if (!(all_ones_framed && ts == 5'h00 && !tx_transparent_mode)) begin
        slot_byte = ALL_ONES; // [RULE13]
      end
    end
  end

  // bit, slot and frame counting
  always_comb begin
    next_div_cnt = bit_en ? 8'h00 : div_cnt + 8'h01;
    next_bit_pos = bit_pos;
    next_ts      = ts;
    next_frame   = frame;
    next_shift   = shift;
    next_out_bit = out_bit;
    if (bit_en) begin
      next_bit_pos = bit_pos + 3'h1;
      if (load) begin
        next_out_bit = slot_byte[7];
        next_shift   = {slot_byte[6:0], 1'b0};
      end else begin
        next_out_bit = shift[7];
        next_shift   = {shift[6:0], 1'b0};
      end
      if (bit_pos == 3'(BITS_PER_TS - 1)) begin
        next_ts = ts + 5'h01;
        if (ts == 5'(TS_PER_FRAME - 1)) begin
          next_frame = frame + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt       <= 8'h00;
      bit_pos       <= 3'h0;
      ts            <= 5'h00;
      frame         <= 4'h0;
      shift         <= 8'h00;
      out_bit       <= 1'b0;
      line_out_tip  <= 1'b0;
      line_out_ring <= 1'b0;
    end else begin
      div_cnt       <= next_div_cnt;
      bit_pos       <= next_bit_pos;
      ts            <= next_ts;
      frame         <= next_frame;
      shift         <= next_shift;
      out_bit       <= next_out_bit;
      line_out_tip  <= next_out_bit;
      line_out_ring <= !next_out_bit;
    end
  end

  // alarm indication detection
  logic [8:0] win_cnt;
  logic [1:0] zero_cnt;
  logic       prev_good;
  logic [8:0] next_win_cnt;
  logic [1:0] next_zero_cnt;
  logic       next_prev_good;
  logic       next_ais;
  logic [1:0] zeros_now;
  logic       good;

  // zeros counted per 512-bit window
  always_comb begin
    next_win_cnt   = win_cnt;
    next_zero_cnt  = zero_cnt;
    next_prev_good = prev_good;
    next_ais       = ais_detected;
    zeros_now      = zero_cnt;
    if (!rx_line_bit && zero_cnt != AIS_ZERO_LIMIT) begin
      zeros_now = zero_cnt + 2'h1;
    end
    good = (zeros_now < AIS_ZERO_LIMIT);
    if (rx_line_valid) begin
      next_win_cnt  = win_cnt + 9'h001;
      next_zero_cnt = zeros_now;
      if (win_cnt == 9'(AIS_WINDOW_BITS - 1)) begin
        next_zero_cnt  = 2'h0;
        next_prev_good = good;
        next_ais = ais_criterion_select ? (good && prev_good) : good; // [RULE1]
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      win_cnt      <= 9'h000;
      zero_cnt     <= 2'h0;
      prev_good    <= 1'b0;
      ais_detected <= 1'b0;
    end else begin
      win_cnt      <= next_win_cnt;
      zero_cnt     <= next_zero_cnt;
      prev_good    <= next_prev_good;
      ais_detected <= next_ais;
    end
  end

  // received E-bit error counting
  logic [ECNT_W-1:0] next_ebit_count;
  logic              next_ebit_event;

  always_comb begin
    next_ebit_event = rx_ebit_valid &&
                      (rx_ebit == ebit_error_polarity); // [RULE14]
    next_ebit_count = ebit_count;
    if (next_ebit_event && ebit_count != {ECNT_W{1'b1}}) begin
      next_ebit_count = ebit_count + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ebit_count       <= '0;
      ebit_error_event <= 1'b0;
    end else begin
      ebit_count       <= next_ebit_count;
      ebit_error_event <= next_ebit_event;
    end
  end
endmodule // e1fmac_top

/* verif/e1fmac_top_asserts.sv */
module e1fmac_top_asserts #(
  parameter int BIT_DIV = e1fmac_pkg::BIT_DIV_DEF
) (
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       rx_ebit,
  input wire logic       rx_ebit_valid,
  input wire logic       line_out_tip,
  input wire logic       interwork_enable,
  input wire logic       crc_enable,
  input wire logic       basic_reframe_start,
  input wire logic       mf_reframe_start,
  input wire logic       ebit_error_event
);
  timeunit 1ns;
  timeprecision 1ps;
  import e1fmac_pkg::*;
  localparam int ONES_SETTLE = 20 * BIT_DIV;
  logic [7:0] mode_sh, next_mode_sh, ones_cnt, next_ones_cnt;
  logic [2:0] bits_sh, next_bits_sh; // framed, ones_n, err_pol
  logic       clr_basic, clr_mf, ebit_hit;

  // shadow of the control words and all-ones dwell count
  always_comb begin
    next_mode_sh = mode_sh;
    next_bits_sh = bits_sh;
    if (reg_wr && reg_addr == OFS_MODE)
      next_mode_sh = reg_wdata;
    if (reg_wr && reg_addr == OFS_ALARM)
      next_bits_sh[1:0] = reg_wdata[ALM_ONES_N -: 2];
    if (reg_wr && reg_addr == OFS_CTRL)
      next_bits_sh[2] = reg_wdata[CTL_ONES_FRM];
    next_ones_cnt = ones_cnt + 8'(ones_cnt != 8'hFF);
    if (bits_sh[1] || bits_sh[2])
      next_ones_cnt = 8'h00;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_sh  <= RST_MODE;
      bits_sh  <= {RST_CTRL[CTL_ONES_FRM], RST_ALARM[ALM_ONES_N -: 2]};
      ones_cnt <= 8'h00;
    end else begin
      mode_sh  <= next_mode_sh;
      bits_sh  <= next_bits_sh;
      ones_cnt <= next_ones_cnt;
    end
  end

  // clearing writes of the reframe bits and counted E bits
  assign clr_basic = reg_wr && reg_addr == OFS_MODE
                     && mode_sh[MODE_BREFRM] && !reg_wdata[MODE_BREFRM];
  assign clr_mf = reg_wr && reg_addr == OFS_MODE
                  && mode_sh[MODE_MREFRM] && !reg_wdata[MODE_MREFRM];
  assign ebit_hit = rx_ebit_valid && rx_ebit == bits_sh[0];

  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence s_clear_basic;
    clr_basic;
  endsequence
  sequence s_clear_mf;
    clr_mf;
  endsequence

  a_crc_follow: assert property (
    crc_enable == !mode_sh[MODE_CRC_DIS]) else $error("crc enable");
  a_iw_follow: assert property (
    interwork_enable == !mode_sh[MODE_IW_DIS]) else $error("interwork");
  a_basic_pulse: assert property (
    s_clear_basic |-> ##2 basic_reframe_start ##1 !basic_reframe_start)
    else $error("basic pulse");
  a_basic_cause: assert property (
    basic_reframe_start |-> $past(clr_basic, 2)) else $error("basic cause");
  a_mf_pulse: assert property (
    s_clear_mf |-> ##2 mf_reframe_start ##1 !mf_reframe_start)
    else $error("mf pulse");
  a_mf_cause: assert property (
    mf_reframe_start |-> $past(clr_mf, 2)) else $error("mf cause");
  a_ebit_count: assert property (
    ebit_hit |=> ebit_error_event) else $error("ebit event");
  a_ebit_cause: assert property (
    ebit_error_event |-> $past(ebit_hit)) else $error("ebit cause");
  a_alarm_low: assert property (
    $past(reg_rd) && $past(reg_addr) == OFS_ALARM |-> reg_rdata[2:0] == 3'h0)
    else $error("alarm low bits");
  a_ones_line: assert property (
    ones_cnt >= ONES_SETTLE |-> line_out_tip) else $error("all ones");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("rdata idle");
endmodule // e1fmac_top_asserts

/* verif/e1fmac_far_end.sv */
module e1fmac_far_end (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic [9:0] zeros_req,
  input  wire logic       ebit_on,
  output logic            rx_line_bit,
  output logic            rx_line_valid,
  output logic            rx_ebit,
  output logic            rx_ebit_valid,
  output logic            sync_ok,
  output logic            mf_aligned,
  output logic            cmp_bit,
  output logic            win_end,
  output logic [15:0]     ebit_zeros,
  output logic [15:0]     ebit_ones
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] bit_pos;
  logic [9:0] zlim;

  // window position, zero limit, E-bit tallies
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_pos    <= 9'h000;
      zlim       <= 10'h000;
      ebit_zeros <= 16'h0000;
      ebit_ones  <= 16'h0000;
    end else begin
      bit_pos <= bit_pos + 9'h001;
      if (win_end)
        zlim <= zeros_req;
      if (rx_ebit_valid && rx_ebit)
        ebit_ones <= ebit_ones + 16'h0001;
      if (rx_ebit_valid && !rx_ebit)
        ebit_zeros <= ebit_zeros + 16'h0001;
    end
  end

  // line, E-bit and status outputs
  always_comb begin
    rx_line_valid = 1'b1;
    rx_line_bit   = 10'(bit_pos) >= zlim;
    win_end       = bit_pos == 9'h1FF;
    rx_ebit_valid = ebit_on && bit_pos[1:0] == 2'h0;
    rx_ebit       = bit_pos[5] ^ bit_pos[2];
    sync_ok       = 1'b1;
    mf_aligned    = bit_pos[8];
    cmp_bit       = bit_pos[3];
  end
endmodule // e1fmac_far_end

/* verif/e1fmac_top_bench.sv */
module e1fmac_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import e1fmac_pkg::*;
  logic              ref_clk, arst_n, reg_wr, reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic [7:0]        serial_tx_input;
  logic              serial_tx_valid, serial_tx_ready, sync_ok, cmp_bit;
  logic              mf_aligned, rx_line_bit, rx_line_valid, rx_ebit;
  logic              rx_ebit_valid, line_out_tip, line_out_ring, win_end;
  logic              ais_detected, interwork_enable, crc_enable, ebit_on;
  logic              basic_reframe_start, mf_reframe_start, ebit_error_event;
  logic [9:0]        zeros_req;
  logic [15:0]       ebit_zeros, ebit_ones;
  int                miscompares, n_checks;

  e1fmac_top #(.BIT_DIV(2), .FIFO_DEPTH(8)) e1fmac_top_i (
    .ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .serial_tx_input, .serial_tx_valid, .serial_tx_ready,
    .basic_sync_ok(sync_ok), .mf_aligned, .crc_sync_ok(sync_ok),
    .crc_cmp_result(cmp_bit), .tx_crc_bit(cmp_bit), .crc_delta_bit(cmp_bit),
    .rx_line_bit, .rx_line_valid, .rx_ebit, .rx_ebit_valid, .line_out_tip,
    .line_out_ring, .ais_detected, .interwork_enable, .crc_enable,
    .basic_reframe_start, .mf_reframe_start, .ebit_error_event);
  e1fmac_far_end e1fmac_far_end_i (
    .ref_clk, .arst_n, .zeros_req, .ebit_on, .rx_line_bit, .rx_line_valid,
    .rx_ebit, .rx_ebit_valid, .sync_ok, .mf_aligned, .cmp_bit, .win_end,
    .ebit_zeros, .ebit_ones);

  // clock and watchdog
  always #50 ref_clk = ~ref_clk;
  initial begin
    #(20000 * 100);
    miscompares++;
    finish_test();
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [4:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic t_regs();
    logic [7:0] d;
    reg_read(OFS_MODE, d);
    check(d, RST_MODE);
    reg_read(OFS_ALARM, d);
    check(d, RST_ALARM);
    reg_read(OFS_CTRL, d);
    check(d, RST_CTRL);
    reg_write(OFS_ALARM, 8'h17);
    reg_read(OFS_ALARM, d);
    check(d, 8'h10);
    reg_write(5'h1F, 8'hA5);
    reg_read(5'h1F, d);
    check(d, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_mode();
    reg_write(OFS_MODE, 8'h24);
    #1;
    check({crc_enable, interwork_enable}, 2'b00);
    reg_write(OFS_MODE, 8'h00);
    #1;
    check({crc_enable, interwork_enable}, 2'b11);
    $display("test mode done");
  endtask

  task automatic t_reframe();
    for (int b = 0; b < 2; b++) begin
      reg_write(OFS_MODE, b ? 8'h02 : 8'h01);
      repeat (520) @(posedge ref_clk);
      reg_write(OFS_MODE, 8'h00);
      @(posedge ref_clk);
      #1;
      check({basic_reframe_start, mf_reframe_start},
            b ? 2'b10 : 2'b01);
      @(posedge ref_clk);
      #1;
      check({basic_reframe_start, mf_reframe_start}, 2'b00);
    end
    $display("test reframe done");
  endtask

  task automatic t_ebit();
    logic [7:0]  lo, hi;
    logic [15:0] c0, p0;
    for (int pol = 0; pol < 2; pol++) begin
      reg_write(OFS_ALARM, pol ? 8'h18 : 8'h10);
      reg_read(OFS_ECNT_L, lo);
      reg_read(OFS_ECNT_H, hi);
      c0 = {hi, lo};
      p0 = pol ? ebit_ones : ebit_zeros;
      @(posedge ref_clk);
      ebit_on <= 1'b1;
      repeat (200) @(posedge ref_clk);
      ebit_on <= 1'b0;
      repeat (4) @(posedge ref_clk);
      reg_read(OFS_ECNT_L, lo);
      reg_read(OFS_ECNT_H, hi);
      check({hi, lo} - c0, (pol ? ebit_ones : ebit_zeros) - p0);
    end
    $display("test ebit done");
  endtask

  task automatic t_ais();
    bit [15:0] steps [5]; // mode, zeros, windows, expected alarm
    steps = '{16'h0025, 16'h0034, 16'h8024, 16'h8023, 16'h8034};
    for (int i = 0; i < 5; i++) begin
      reg_write(OFS_MODE, steps[i][15:8]);
      zeros_req <= 10'(steps[i][7:4]);
      repeat (int'(steps[i][3:1])) @(posedge ref_clk iff win_end);
      repeat (3) @(posedge ref_clk);
      #1;
      check(ais_detected, steps[i][0]);
    end
    reg_write(OFS_MODE, 8'h00);
    $display("test ais done");
  endtask

  task automatic t_all_ones();
    int zeros;
    for (int framed = 0; framed < 2; framed++) begin
      reg_write(OFS_CTRL, framed ? 8'h34 : 8'h30);
      reg_write(OFS_ALARM, 8'h00);
      zeros = 0;
      repeat (40) @(posedge ref_clk);
      repeat (600) begin
        @(posedge ref_clk);
        zeros += (line_out_tip === 1'b0);
      end
      check(zeros != 0, framed);
      check(line_out_ring, !line_out_tip);
      reg_write(OFS_ALARM, 8'h10);
    end
    reg_write(OFS_CTRL, 8'h30);
    $display("test all ones done");
  endtask

  task automatic t_fifo();
    logic [7:0] d;
    int         i;
    @(posedge ref_clk);
    serial_tx_input <= 8'h5A;
    serial_tx_valid <= 1'b1;
    for (i = 0; i < 20 && serial_tx_ready === 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    check(serial_tx_ready, 1'b0);
    @(posedge ref_clk);
    serial_tx_valid <= 1'b0;
    d = 8'hFF;
    for (i = 0; i < 80 && d[4] !== 1'b0; i++)
      reg_read(OFS_STATUS, d);
    check(d[4], 1'b0);
    $display("test fifo done");
  endtask

  task automatic finish_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // reset, then the scenarios in turn
  initial begin
    ref_clk = 1'b0;
    arst_n = 1'b0;
    {reg_wr, reg_rd, serial_tx_valid, ebit_on} = 4'h0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    serial_tx_input = 8'h00;
    zeros_req = 10'h003;
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_regs();
    t_mode();
    t_reframe();
    t_ebit();
    t_ais();
    t_all_ones();
    t_fifo();
    finish_test();
  end
endmodule // e1fmac_top_bench

bind e1fmac_top e1fmac_top_asserts #(.BIT_DIV(BIT_DIV)) e1fmac_top_asserts_i (
  .ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .rx_ebit, .rx_ebit_valid, .line_out_tip, .interwork_enable, .crc_enable,
  .basic_reframe_start, .mf_reframe_start, .ebit_error_event);
